// *** src/gpio_ports_g_h_j.sv ***
`timescale 1ns/10ps
`include "gpio_ghj_consts.svh"

// Functional notes
// - A direction bit of one makes the pin an input with no drive, zero drives it from the latch.
// - Reading a data register returns pin levels, zero on analog pins, writing it only loads that port's latch.
// - Ports G, H and J each have eight pins with their own direction and data registers.
// - Port G pins three to zero can be handed to the converter by the analog pin setting.
// - After reset port G pins three to zero are analog until software makes them digital.
// - In analog mode port G pin zero is channel three and pin one is channel two.
// - Port G pin two is channel one or low reference, pin three channel zero or high reference.
// - Port G pin four feeds capture three and pin five can carry pulse output three.
// - Port G pins six and seven carry the second serial unit's receive/data and transmit/clock.
// - Port H pins four to seven can serve converter channels twelve to fifteen.
// - After reset port H pins seven to four are analog until software makes them digital.
// - Port H pins three to zero are plain digital I/O.
// - All port J pins are plain digital I/O.
// - Direction registers reset to all ones on every kind of reset.
// - Port G registers are reached only while bank select holds five.
module gpio_ports_g_h_j #(
    parameter int PORT_W = `PORT_WIDTH
) (
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    // Register port
    input  wire gpio_ghj_pkg::bus_req_s i_req,
    output logic [7:0]                  o_rdata,
    // Port G pads
    input  wire logic [PORT_W-1:0]      i_pin_g,
    output gpio_ghj_pkg::pad_drive_s    o_pad_g,
    // Port H pads
    input  wire logic [PORT_W-1:0]      i_pin_h,
    output gpio_ghj_pkg::pad_drive_s    o_pad_h,
    // Port J pads
    input  wire logic [PORT_W-1:0]      i_pin_j,
    output gpio_ghj_pkg::pad_drive_s    o_pad_j,
    // Converter side
    output logic [3:0]                  o_analog_g,
    output logic [3:0]                  o_analog_h,
    output logic [7:0]                  o_adc_config,
    // Capture three
    output logic                        o_capture_three_in,
    // Pulse output three
    input  wire logic                   i_pulse_out_three,
    input  wire logic                   i_pulse_out_three_en,
    // Second serial unit
    input  wire logic                   i_serial_two_en,
    input  wire logic                   i_serial_two_rx_data,
    input  wire logic                   i_serial_two_rx_data_drv,
    input  wire logic                   i_serial_two_tx_clk,
    input  wire logic                   i_serial_two_tx_clk_drv,
    output logic                        o_serial_two_rx_data,
    output logic                        o_serial_two_tx_clk
);

    localparam int NPINS = 3 * PORT_W;

    // The pad structs and channel maps are fixed at eight pins a port
    if (PORT_W != `PORT_WIDTH) begin : g_width_check
        $error("gpio_ports_g_h_j: PORT_W must be 8");
    end

    // Software-visible state
    logic [PORT_W-1:0] dir_g_q;
    logic [PORT_W-1:0] dir_h_q;
    logic [PORT_W-1:0] dir_j_q;
    logic [PORT_W-1:0] pins_g_q;
    logic [PORT_W-1:0] pins_h_q;
    logic [PORT_W-1:0] pins_j_q;
    logic [7:0]        adc_config_q;

    // Pin input path, three stages then an agreement filter
    logic [NPINS-1:0]  sync1_q;
    logic [NPINS-1:0]  sync2_q;
    logic [NPINS-1:0]  sync3_q;
    logic [NPINS-1:0]  level_q;

    // Combinational helpers
    logic              sel_low;
    logic              sel_high;
    logic              analog_on;
    logic [NPINS-1:0]  analog_mask;
    logic [NPINS-1:0]  drive_en;
    logic [NPINS-1:0]  drive_val;
    logic [NPINS-1:0]  read_level;
    logic [7:0]        rdata_d;

    // Bank decode; registers outside the selected bank are invisible
    assign sel_low  = (i_req.bank == `BANK_LOW);
    assign sel_high = (i_req.bank == `BANK_HIGH);

    // Codes below the all-digital code keep the shared pins analog
    assign analog_on = (adc_config_q[`PCFG_MSB:`PCFG_LSB] < `PCFG_DIGITAL_MIN);

    // Direction registers, all inputs after any reset
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            dir_g_q <= `DIR_RESET;
            dir_h_q <= `DIR_RESET;
            dir_j_q <= `DIR_RESET;
        end else if (i_req.wr) begin
            if (sel_low && i_req.addr == `OFS_DIR_G) begin
                dir_g_q <= i_req.wdata;
            end
            if (sel_high && i_req.addr == `OFS_DIR_H) begin
                dir_h_q <= i_req.wdata;
            end
            if (sel_high && i_req.addr == `OFS_DIR_J) begin
                dir_j_q <= i_req.wdata;
            end
        end
    end

    // Output latches; a data write never touches direction or pins
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pins_g_q <= `LATCH_RESET;
            pins_h_q <= `LATCH_RESET;
            pins_j_q <= `LATCH_RESET;
        end else if (i_req.wr) begin
            if (sel_low && i_req.addr == `OFS_PINS_G) begin
                pins_g_q <= i_req.wdata;
            end
            if (sel_high && i_req.addr == `OFS_PINS_H) begin
                pins_h_q <= i_req.wdata;
            end
            if (sel_high && i_req.addr == `OFS_PINS_J) begin
                pins_j_q <= i_req.wdata;
            end
        end
    end

    // Converter setting; zero at reset leaves the shared pins analog
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            adc_config_q <= `ADC_CONFIG_RESET;
        end else if (i_req.wr && sel_low && i_req.addr == `OFS_ADC_CONFIG) begin
            adc_config_q <= i_req.wdata & `ADC_CONFIG_MASK;
        end
    end

    // Pin synchroniser chain; stage one feeds only stage two
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= {i_pin_j, i_pin_h, i_pin_g};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // A level is accepted once stages two and three agree
    for (genvar k = 0; k < NPINS; k++) begin : g_filter
        always_ff @(posedge i_clk_sys or posedge i_rst) begin
            if (i_rst) begin
                level_q[k] <= 1'b0;
            end else if (sync2_q[k] == sync3_q[k]) begin
                level_q[k] <= sync3_q[k];
            end
        end
    end

    // Analog pin map: G3..G0 and H7..H4 only
    always_comb begin
        analog_mask = '0;
        analog_mask[3:0] = {4{analog_on}};
        analog_mask[PORT_W+7:PORT_W+4] = {4{analog_on}};
    end

    // Pad drive selection; H3..H0 and all of J take the plain path
    always_comb begin
        drive_val = {pins_j_q, pins_h_q, pins_g_q};
        drive_en  = ~{dir_j_q, dir_h_q, dir_g_q} & ~analog_mask;
        // Pulse output replaces the latch, the direction bit still gates it
        if (i_pulse_out_three_en) begin
            drive_val[`G_PULSE_BIT] = i_pulse_out_three;
        end
        // Serial unit owns both pins and their drivers while enabled
        if (i_serial_two_en) begin
            drive_val[`G_RX_BIT] = i_serial_two_rx_data;
            drive_en[`G_RX_BIT]  = i_serial_two_rx_data_drv;
            drive_val[`G_TX_BIT] = i_serial_two_tx_clk;
            drive_en[`G_TX_BIT]  = i_serial_two_tx_clk_drv;
        end
    end

    // Registered pad outputs; all released during reset
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pad_g <= '{level: `LATCH_RESET, oe_n: `DIR_RESET};
            o_pad_h <= '{level: `LATCH_RESET, oe_n: `DIR_RESET};
            o_pad_j <= '{level: `LATCH_RESET, oe_n: `DIR_RESET};
        end else begin
            o_pad_g.level <= drive_val[PORT_W-1:0];
            o_pad_g.oe_n  <= ~drive_en[PORT_W-1:0];
            o_pad_h.level <= drive_val[2*PORT_W-1:PORT_W];
            o_pad_h.oe_n  <= ~drive_en[2*PORT_W-1:PORT_W];
            o_pad_j.level <= drive_val[NPINS-1:2*PORT_W];
            o_pad_j.oe_n  <= ~drive_en[NPINS-1:2*PORT_W];
        end
    end

    // Peripheral inputs see the filtered pin, even while it drives
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_capture_three_in   <= 1'b0;
            o_serial_two_rx_data <= 1'b0;
            o_serial_two_tx_clk  <= 1'b0;
        end else begin
            o_capture_three_in   <= level_q[`G_CAPTURE_BIT];
            o_serial_two_rx_data <= level_q[`G_RX_BIT];
            o_serial_two_tx_clk  <= level_q[`G_TX_BIT];
        end
    end

    // Converter hookup flags, bit n is the pin n of the shared nibble
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_analog_g   <= 4'hF;
            o_analog_h   <= 4'hF;
            o_adc_config <= `ADC_CONFIG_RESET;
        end else begin
            o_analog_g   <= analog_mask[3:0];
            o_analog_h   <= analog_mask[PORT_W+7:PORT_W+4];
            o_adc_config <= adc_config_q;
        end
    end

    // Analog pins read zero so stray thresholds never reach software
    assign read_level = level_q & ~analog_mask;

    // Read mux; pins registers show the pads, not the latch
    always_comb begin
        rdata_d = 8'h00;
        if (sel_low) begin
            case (i_req.addr)
                `OFS_DIR_G:      rdata_d = dir_g_q;
                `OFS_PINS_G:     rdata_d = read_level[PORT_W-1:0];
                `OFS_ADC_CONFIG: rdata_d = adc_config_q;
                default:         rdata_d = 8'h00;
            endcase
        end else if (sel_high) begin
            case (i_req.addr)
                `OFS_DIR_H:  rdata_d = dir_h_q;
                `OFS_PINS_H: rdata_d = read_level[2*PORT_W-1:PORT_W];
                `OFS_DIR_J:  rdata_d = dir_j_q;
                `OFS_PINS_J: rdata_d = read_level[NPINS-1:2*PORT_W];
                default:     rdata_d = 8'h00;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_req.rd) begin
            o_rdata <= rdata_d;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule // gpio_ports_g_h_j

// *** src/gpio_ghj_consts.svh ***
`ifndef GPIO_GHJ_CONSTS_SVH
`define GPIO_GHJ_CONSTS_SVH

// Pins per port
`define PORT_WIDTH       8
// Bank select values that open each register group
`define BANK_LOW         4'h5
`define BANK_HIGH        4'h8
// Offsets inside bank five
`define OFS_DIR_G        8'h12
`define OFS_PINS_G       8'h13
`define OFS_ADC_CONFIG   8'h15
// Offsets inside bank eight
`define OFS_DIR_H        8'h10
`define OFS_PINS_H       8'h11
`define OFS_DIR_J        8'h12
`define OFS_PINS_J       8'h13
// Reset values
`define DIR_RESET        8'hFF
`define LATCH_RESET      8'h00
`define ADC_CONFIG_RESET 8'h00
// Bit four of the converter setting is unimplemented
`define ADC_CONFIG_MASK  8'hEF
// Analog pin configuration field and the first all-digital code
`define PCFG_MSB         3
`define PCFG_LSB         0
`define PCFG_DIGITAL_MIN 4'hE
// Port G pins with peripheral duties
`define G_CAPTURE_BIT    4
`define G_PULSE_BIT      5
`define G_RX_BIT         6
`define G_TX_BIT         7

`endif

// *** src/gpio_ghj_pkg.sv ***
package gpio_ghj_pkg;

    // One register access: bank, offset, data and the two strobes
    typedef struct packed {
        logic [3:0] bank;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    // Pad drive for one 8-pin port; oe_n low means the pin is driven
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] oe_n;
    } pad_drive_s;

endpackage

// *** test/gpio_ports_g_h_j_props.sv ***
`timescale 1ns/10ps
// Port-level checks of the G, H and J port block
module gpio_ports_g_h_j_props #(
    parameter int PORT_W = 8
) (
    // Clock, reset and bus
    input wire logic                     i_clk_sys,
    input wire logic                     i_rst,
    input wire gpio_ghj_pkg::bus_req_s   i_req,
    input wire logic [7:0]               o_rdata,
    // Pads and converter
    input wire logic [PORT_W-1:0]        i_pin_g,
    input wire gpio_ghj_pkg::pad_drive_s o_pad_g,
    input wire gpio_ghj_pkg::pad_drive_s o_pad_h,
    input wire gpio_ghj_pkg::pad_drive_s o_pad_j,
    input wire logic [3:0]               o_analog_g,
    input wire logic [3:0]               o_analog_h,
    input wire logic [7:0]               o_adc_config,
    // Peripherals
    input wire logic                     o_capture_three_in,
    input wire logic                     o_serial_two_rx_data,
    input wire logic                     i_serial_two_en,
    input wire logic                     i_serial_two_tx_clk,
    input wire logic                     i_serial_two_tx_clk_drv
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_rdata_idle; !i_req.rd |=> o_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_bank_refused;
        i_req.rd && !(i_req.bank inside {4'h5, 4'h8}) |=> o_rdata == 8'h00;
    endproperty
    a_bank_refused: assert property (p_bank_refused) else $error("foreign bank read");
    property p_reset_out;
        $fell(i_rst) |-> (o_pad_g.oe_n & o_pad_h.oe_n & o_pad_j.oe_n) == 8'hff
            && o_analog_g == 4'hf && o_analog_h == 4'hf;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("bad state after reset");
    // Settled converter setting fixes analog hand-over and pad drive
    property p_analog;
        $stable(o_adc_config) [*3] |-> o_analog_g == {4{o_adc_config[3:0] < 4'he}}
            && o_analog_h == o_analog_g && (o_pad_g.oe_n[3:0] | ~o_analog_g) == 4'hf
            && (o_pad_h.oe_n[7:4] | ~o_analog_h) == 4'hf;
    endproperty
    a_analog: assert property (p_analog) else $error("analog map wrong");
    property p_j_latch;
        i_req.wr && i_req.bank == 4'h8 && i_req.addr == 8'h13 |=> ##1
            ((o_pad_j.level ^ $past(i_req.wdata, 2)) & ~o_pad_j.oe_n) == 8'h00;
    endproperty
    a_j_latch: assert property (p_j_latch) else $error("port j latch lost");
    property p_j_dir;
        i_req.wr && i_req.bank == 4'h8 && i_req.addr == 8'h12 |=> ##1
            o_pad_j.oe_n == $past(i_req.wdata, 2);
    endproperty
    a_j_dir: assert property (p_j_dir) else $error("port j direction lost");
    property p_inputs;
        $stable(i_pin_g) [*7] |->
            o_capture_three_in == i_pin_g[4] && o_serial_two_rx_data == i_pin_g[6];
    endproperty
    a_inputs: assert property (p_inputs) else $error("peripheral input wrong");
    property p_serial_tx;
        (i_serial_two_en && i_serial_two_tx_clk_drv && $stable(i_serial_two_tx_clk)) [*2]
            |-> !o_pad_g.oe_n[7] && o_pad_g.level[7] == i_serial_two_tx_clk;
    endproperty
    a_serial_tx: assert property (p_serial_tx) else $error("serial clock pin wrong");
    c_read: cover property (i_req.rd ##1 o_rdata != 8'h00);
    c_digital: cover property (o_analog_g == 4'h0);
    c_serial: cover property (!o_pad_g.oe_n[7] && i_serial_two_en);
endmodule // gpio_ports_g_h_j_props

bind gpio_ports_g_h_j gpio_ports_g_h_j_props #(.PORT_W(PORT_W)) u_props (.i_clk_sys, .i_rst,
    .i_req, .o_rdata, .i_pin_g, .o_pad_g, .o_pad_h, .o_pad_j, .o_analog_g, .o_analog_h,
    .o_adc_config, .o_capture_three_in, .o_serial_two_rx_data, .i_serial_two_en,
    .i_serial_two_tx_clk, .i_serial_two_tx_clk_drv);

// *** test/pad_world.sv ***
`timescale 1ns/10ps
// Far side of one port: device pad, an outside driver and floating lines
module pad_world (
    // Clock
    input  wire logic                     i_clk_sys,
    // Device pad and outside driver
    input  wire gpio_ghj_pkg::pad_drive_s i_pad,
    input  wire logic [7:0]               i_ext,
    input  wire logic [7:0]               i_ext_en,
    // Resolved levels
    output logic [7:0]                    o_pin
);
    logic [7:0] float_q = 8'h5a;
    // No pull resistors, so an undriven line wanders every cycle
    always_ff @(posedge i_clk_sys) begin
        float_q <= ~float_q;
    end
    // Device wins where it drives, then the outside driver
    assign o_pin = (i_pad.level & ~i_pad.oe_n) | (i_pad.oe_n & i_ext & i_ext_en)
        | (i_pad.oe_n & float_q & ~i_ext_en);
endmodule // pad_world

// *** test/gpio_ports_g_h_j_test.sv ***
`timescale 1ns/10ps
// Self-checking bench of the G, H and J port block
module gpio_ports_g_h_j_test;
    logic                     clk_sys, rst, pwm, pwm_en, ser_en, tx, tx_drv, cap, rx_o, tx_o;
    logic                     rx_drv;
    gpio_ghj_pkg::bus_req_s   req;
    gpio_ghj_pkg::pad_drive_s pad [3];
    logic [7:0]               rdata, adc, ext [3], ext_en [3], pin [3];
    logic [3:0]               ana_g, ana_h;
    logic [31:0]              seed = 32'hffea_16f3;
    int                       failures, checks_done;
    localparam logic [3:0] BK [3] = '{4'h5, 4'h8, 4'h8};
    localparam logic [7:0] OD [3] = '{8'h12, 8'h10, 8'h12};

    gpio_ports_g_h_j u_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_req(req), .o_rdata(rdata),
        .i_pin_g(pin[0]), .o_pad_g(pad[0]), .i_pin_h(pin[1]), .o_pad_h(pad[1]),
        .i_pin_j(pin[2]), .o_pad_j(pad[2]), .o_analog_g(ana_g), .o_analog_h(ana_h),
        .o_adc_config(adc), .o_capture_three_in(cap), .i_pulse_out_three(pwm),
        .i_pulse_out_three_en(pwm_en), .i_serial_two_en(ser_en),
        .i_serial_two_rx_data(pwm), .i_serial_two_rx_data_drv(rx_drv),
        .i_serial_two_tx_clk(tx), .i_serial_two_tx_clk_drv(tx_drv),
        .o_serial_two_rx_data(rx_o), .o_serial_two_tx_clk(tx_o));
    for (genvar p = 0; p < 3; p++) begin : g_far
        pad_world u_far (.i_clk_sys(clk_sys), .i_pad(pad[p]), .i_ext(ext[p]),
            .i_ext_en(ext_en[p]), .o_pin(pin[p]));
    end

    // Xorshift source, fixed seed keeps runs repeatable
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Inputs show the pins, outputs the latch
    function automatic logic [7:0] exp_rd(input logic [7:0] dr, e, d);
        return (dr & e) | (~dr & d);
    endfunction
    task automatic chk(input logic [7:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access; read data stand only in the cycle after the strobe
    task automatic bus(input logic [3:0] b, input logic [7:0] a, d, input logic w,
                       input logic [7:0] e);
        @(posedge clk_sys);
        req <= '{b, a, d, w, !w};
        @(posedge clk_sys);
        req <= '0;
        #1;
        if (!w) chk(rdata, e);
    endtask
    // Input filter needs about five edges
    task automatic settle;
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Guard against a hung run
    initial begin
        #2000000;
        failures++;
        conclude;
    end
    initial begin
        logic [7:0] d, dr, e;
        {rst, pwm, pwm_en, ser_en, tx, tx_drv} = 6'b100000;
        rx_drv = 1'b0;
        req = '0;
        ext = '{3{8'h00}};
        ext_en = '{3{8'hff}};
        repeat (5) @(posedge clk_sys);
        rst <= 0;
        for (int p = 0; p < 3; p++) bus(BK[p], OD[p], 0, 0, 8'hff);
        $display("test reset done");
        e = rnd();
        ext[0] <= e;
        ext[1] <= e;
        settle;
        bus(4'h5, 8'h13, 0, 0, e & 8'hf0);
        bus(4'h8, 8'h11, 0, 0, e & 8'h0f);
        bus(4'h5, 8'h15, 8'hfe, 1, 0);
        bus(4'h5, 8'h15, 0, 0, 8'hee);
        chk(adc, 8'hee);
        settle;
        bus(4'h5, 8'h13, 0, 0, e);
        bus(4'h8, 8'h11, 0, 0, e);
        $display("test analog done");
        for (int i = 0; i < 24; i++) begin
            automatic int p = i % 3;
            d = rnd();
            dr = (i < 3) ? 8'h00 : (i > 20) ? 8'hff : rnd();
            e = rnd();
            bus(BK[p], OD[p] + 8'h01, 8'h00, 1, 0);
            bus(BK[p], OD[p] + 8'h01, d, 1, 0);
            bus(BK[p], OD[p], dr, 1, 0);
            bus(4'h3, OD[p], ~dr, 1, 0);
            ext[p] <= e;
            ext_en[p] <= dr;
            settle;
            chk(pad[p].oe_n, dr);
            chk(pad[p].level | dr, d | dr);
            bus(BK[p], OD[p] + 8'h01, 0, 0, exp_rd(dr, e, d));
            bus(4'h3, OD[p] + 8'h01, 0, 0, 8'h00);
        end
        $display("test ports done");
        bus(4'h5, 8'h12, 8'h50, 1, 0);
        ext_en[0] <= 8'h50;
        {pwm_en, ser_en, tx_drv} <= 3'b111;
        for (int k = 0; k < 4; k++) begin
            e = rnd();
            pwm <= e[0];
            tx <= e[1];
            // Serial data pin alternates between listening and driving
            rx_drv <= e[2];
            ext[0] <= e;
            settle;
            chk(pad[0].level[5], e[0]);
            chk(cap, e[4]);
            chk({pad[0].oe_n[6], pad[0].level[7], tx_o}, {~e[2], e[1], e[1]});
            chk(rx_o, e[2] ? e[0] : e[6]);
        end
        $display("test peripherals done");
        {pwm_en, ser_en, rx_drv} <= 3'b000;
        bus(4'h5, 8'h15, 8'h00, 1, 0);
        settle;
        chk({ana_g, pad[0].oe_n[3:0]}, 8'hff);
        rst <= 1;
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        bus(4'h5, 8'h12, 0, 0, 8'hff);
        chk(ana_h, 4'hf);
        $display("test second reset done");
        conclude;
    end
endmodule // gpio_ports_g_h_j_test
